//--- rtl/ipsr_defs.vh
// Summary of operation
// - field value all ones routes the input from remappable pin 127
// - field value 1 routes the input from comparator one output
// - field value 0 ties the routed input low
// - bits without a selector field ignore writes and read zero
// - all fields read/write, cleared to zero at reset
// - register 31 bits 14:8 select port 4 clock input source
// - register 31 bits 6:0 select port 4 data input source
// - register 32 bits 6:0 select port 4 slave select; upper bits unused
// - register 33 bits 14:8 select capture 10 source
// - register 33 bits 6:0 select capture 9 source
// - register 34 bits 14:8 capture 12, bits 6:0 capture 11
// - register 35 bits 14:8 capture 14, bits 6:0 capture 13
// - register 36 bits 14:8 capture 16, bits 6:0 capture 15
// - register 37 bits 14:8 select pwm sync input 1 source
// - register 37 bits 6:0 select compare fault c source
`ifndef IPSR_DEFS_VH
`define IPSR_DEFS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define IPSR_ADDR_SPI4_CLK_DATA 12'h000
`define IPSR_ADDR_SPI4_SEL 12'h004
`define IPSR_ADDR_CAP_9_10 12'h008
`define IPSR_ADDR_CAP_11_12 12'h00c
`define IPSR_ADDR_CAP_13_14 12'h010
`define IPSR_ADDR_CAP_15_16 12'h014
`define IPSR_ADDR_PWM_FAULT 12'h018
// ----------------------------------------
// fields
// ----------------------------------------
`define IPSR_HI_MSB 14
`define IPSR_HI_LSB 8
`define IPSR_LO_MSB 6
`define IPSR_LO_LSB 0
`define IPSR_FIELD_RESET 7'h00
`define IPSR_SEL_VSS 7'h00
`define IPSR_SEL_CMP 7'h01
`define IPSR_SEL_LAST 7'h7f
`define IPSR_NUM_REGS 7
`endif

//--- rtl/ipsr_route.v
`timescale 1ns/1ns
`include "ipsr_defs.vh"
module ipsr_route
(
   input wire mclk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [127:0] remappable_pin_n,
   input wire comparator_one_output,
   output reg port4_clock_input,
   output reg port4_data_input,
   output reg port4_slave_sel_input,
   output reg [16:9] capture_input,
   output reg pwm_sync1_input,
   output reg compare_fault_c_input
);

// ----------------------------------------
// pin synchronisers, three stages
// ----------------------------------------
reg [127:0] pin_s1;
reg [127:0] pin_s2;
reg [127:0] pin_s3;
reg [127:0] pin_ok;
reg cmp_s1;
reg cmp_s2;
reg cmp_s3;
reg cmp_ok;

always @(posedge mclk or negedge resetn)
begin
   if (!resetn)
   begin
      pin_s1 <= 128'h0;
      pin_s2 <= 128'h0;
      pin_s3 <= 128'h0;
      pin_ok <= 128'h0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_ok <= 1'b0;
   end
   else
   begin
      pin_s1 <= remappable_pin_n;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // change counts once stages two and three agree, else hold
      pin_ok <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_ok & (pin_s2 ^ pin_s3));
      cmp_s1 <= comparator_one_output;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3)
      begin
         cmp_ok <= cmp_s3;
      end
   end
end

// ----------------------------------------
// selector registers
// ----------------------------------------
reg [6:0] port4_clock_in_select;
reg [6:0] port4_data_in_select;
reg [6:0] port4_slave_sel_select;
reg [6:0] capture9_select;
reg [6:0] capture10_select;
reg [6:0] capture11_select;
reg [6:0] capture12_select;
reg [6:0] capture13_select;
reg [6:0] capture14_select;
reg [6:0] capture15_select;
reg [6:0] capture16_select;
reg [6:0] pwm_sync1_select;
reg [6:0] compare_fault_c_select;

// write lands only at the edge that completes the access
wire wr_en = psel && penable && pwrite && pready;

function hit;
   input [11:0] a;
   begin
      hit = (a == `IPSR_ADDR_SPI4_CLK_DATA) || (a == `IPSR_ADDR_SPI4_SEL)
         || (a == `IPSR_ADDR_CAP_9_10) || (a == `IPSR_ADDR_CAP_11_12)
         || (a == `IPSR_ADDR_CAP_13_14) || (a == `IPSR_ADDR_CAP_15_16)
         || (a == `IPSR_ADDR_PWM_FAULT);
   end
endfunction

// pack two fields, unused bits zero
function [31:0] pack;
   input [6:0] hi;
   input [6:0] lo;
   begin
      pack = {17'h0, hi, 1'b0, lo};
   end
endfunction

always @(posedge mclk or negedge resetn)
begin
   if (!resetn)
   begin
      port4_clock_in_select <= `IPSR_FIELD_RESET;
      port4_data_in_select <= `IPSR_FIELD_RESET;
      port4_slave_sel_select <= `IPSR_FIELD_RESET;
      capture9_select <= `IPSR_FIELD_RESET;
      capture10_select <= `IPSR_FIELD_RESET;
      capture11_select <= `IPSR_FIELD_RESET;
      capture12_select <= `IPSR_FIELD_RESET;
      capture13_select <= `IPSR_FIELD_RESET;
      capture14_select <= `IPSR_FIELD_RESET;
      capture15_select <= `IPSR_FIELD_RESET;
      capture16_select <= `IPSR_FIELD_RESET;
      pwm_sync1_select <= `IPSR_FIELD_RESET;
      compare_fault_c_select <= `IPSR_FIELD_RESET;
   end
   else if (wr_en)
   begin
      case (paddr)
         `IPSR_ADDR_SPI4_CLK_DATA:
         begin
            port4_clock_in_select <= pwdata[`IPSR_HI_MSB:`IPSR_HI_LSB];
            port4_data_in_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         `IPSR_ADDR_SPI4_SEL:
         begin
            port4_slave_sel_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         `IPSR_ADDR_CAP_9_10:
         begin
            capture10_select <= pwdata[`IPSR_HI_MSB:`IPSR_HI_LSB];
            capture9_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         `IPSR_ADDR_CAP_11_12:
         begin
            capture12_select <= pwdata[`IPSR_HI_MSB:`IPSR_HI_LSB];
            capture11_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         `IPSR_ADDR_CAP_13_14:
         begin
            capture14_select <= pwdata[`IPSR_HI_MSB:`IPSR_HI_LSB];
            capture13_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         `IPSR_ADDR_CAP_15_16:
         begin
            capture16_select <= pwdata[`IPSR_HI_MSB:`IPSR_HI_LSB];
            capture15_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         `IPSR_ADDR_PWM_FAULT:
         begin
            pwm_sync1_select <= pwdata[`IPSR_HI_MSB:`IPSR_HI_LSB];
            compare_fault_c_select <= pwdata[`IPSR_LO_MSB:`IPSR_LO_LSB];
         end
         default:
         begin
            port4_slave_sel_select <= port4_slave_sel_select;
         end
      endcase
   end
end

// ----------------------------------------
// apb answer, zero wait states
// ----------------------------------------
reg [31:0] next_prdata;

always @*
begin
   case (paddr)
      `IPSR_ADDR_SPI4_CLK_DATA:
         next_prdata = pack(port4_clock_in_select, port4_data_in_select);
      `IPSR_ADDR_SPI4_SEL:
         next_prdata = pack(7'h00, port4_slave_sel_select);
      `IPSR_ADDR_CAP_9_10:
         next_prdata = pack(capture10_select, capture9_select);
      `IPSR_ADDR_CAP_11_12:
         next_prdata = pack(capture12_select, capture11_select);
      `IPSR_ADDR_CAP_13_14:
         next_prdata = pack(capture14_select, capture13_select);
      `IPSR_ADDR_CAP_15_16:
         next_prdata = pack(capture16_select, capture15_select);
      `IPSR_ADDR_PWM_FAULT:
         next_prdata = pack(pwm_sync1_select, compare_fault_c_select);
      default:
         next_prdata = 32'h0;
   endcase
end

// pready raised in the first access cycle, dropped after
always @(posedge mclk or negedge resetn)
begin
   if (!resetn)
   begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
   end
   else
   begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit(paddr);
      prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0;
   end
end

// ----------------------------------------
// source selection
// ----------------------------------------
function route;
   input [6:0] sel;
   input [127:0] pins;
   input cmp;
   begin
      case (sel)
         `IPSR_SEL_VSS: route = 1'b0;
         `IPSR_SEL_CMP: route = cmp;
         `IPSR_SEL_LAST: route = pins[127];
         default: route = pins[sel];
      endcase
   end
endfunction

always @(posedge mclk or negedge resetn)
begin
   if (!resetn)
   begin
      port4_clock_input <= 1'b0;
      port4_data_input <= 1'b0;
      port4_slave_sel_input <= 1'b0;
      capture_input <= 8'h00;
      pwm_sync1_input <= 1'b0;
      compare_fault_c_input <= 1'b0;
   end
   else
   begin
      port4_clock_input <= route(port4_clock_in_select, pin_ok, cmp_ok);
      port4_data_input <= route(port4_data_in_select, pin_ok, cmp_ok);
      port4_slave_sel_input <= route(port4_slave_sel_select, pin_ok, cmp_ok);
      capture_input[9] <= route(capture9_select, pin_ok, cmp_ok);
      capture_input[10] <= route(capture10_select, pin_ok, cmp_ok);
      capture_input[11] <= route(capture11_select, pin_ok, cmp_ok);
      capture_input[12] <= route(capture12_select, pin_ok, cmp_ok);
      capture_input[13] <= route(capture13_select, pin_ok, cmp_ok);
      capture_input[14] <= route(capture14_select, pin_ok, cmp_ok);
      capture_input[15] <= route(capture15_select, pin_ok, cmp_ok);
      capture_input[16] <= route(capture16_select, pin_ok, cmp_ok);
      pwm_sync1_input <= route(pwm_sync1_select, pin_ok, cmp_ok);
      compare_fault_c_input <= route(compare_fault_c_select, pin_ok, cmp_ok);
   end
end

endmodule // ipsr_route

//--- tb/ipsr_pins.sv
`timescale 1ns/1ns
module ipsr_pins
(
   input wire logic flip,
   output logic [127:0] pins,
   output logic cmp
);
   // odd pins high while flip is low
   assign pins = {64{2'b10}} ^ {128{flip}};
   assign cmp = flip;
endmodule // ipsr_pins

//--- tb/ipsr_route_sva.sv
`timescale 1ns/1ns
module ipsr_route_sva
(
   input wire mclk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire port4_data_input,
   input wire compare_fault_c_input
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   a_ready_after_setup:
      assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_single:
      assert property (pready |=> !pready) else $error("ready held");
   a_rdata_idle:
      assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
   a_read_upper_zero:
      assert property (pready && !pwrite |-> prdata[31:15] == 17'h0 && !prdata[7])
      else $error("unused bits not zero");
   a_sel_upper_zero:
      assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[15:7] == 9'h0)
      else $error("select register upper bits set");
   a_err_only_ready:
      assert property (pslverr |-> pready) else $error("error without ready");
   a_err_unmapped:
      assert property (pready |-> pslverr == (paddr > 12'h018 || paddr[1:0] != 2'b00))
      else $error("error flag wrong");
   a_reset_clear:
      assert property ($rose(resetn) |-> !pready && !port4_data_input && !compare_fault_c_input)
      else $error("outputs not clear after reset");
   a_fault_low_route:
      assert property (psel && penable && pready && pwrite && paddr == 12'h018
         && pwdata[6:0] == 7'h0 |-> ##2 !compare_fault_c_input) else $error("fault input not low");
endmodule // ipsr_route_sva
bind ipsr_route ipsr_route_sva u_sva (.mclk(mclk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .port4_data_input(port4_data_input),
   .compare_fault_c_input(compare_fault_c_input));

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic mclk, resetn, psel, penable, pwrite, flip, pready, pslverr, er, cmp;
   logic p4c, p4d, p4s, pws, flt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [127:0] pins;
   logic [16:9] cap;
   logic [13:0] routed;
   logic [15:0] rows [0:6];
   int fail_count, tests_run, cyc, i, n;
   assign routed = {pws, flt, cap, 1'b0, p4s, p4c, p4d};
   ipsr_pins u_pins (.flip(flip), .pins(pins), .cmp(cmp));
   ipsr_route uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .remappable_pin_n(pins), .comparator_one_output(cmp),
      .port4_clock_input(p4c), .port4_data_input(p4d), .port4_slave_sel_input(p4s),
      .capture_input(cap), .pwm_sync1_input(pws), .compare_fault_c_input(flt));
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ------------------------------
   // bus cycles and checks
   // ------------------------------
   task stop_test;
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // routed level expected for a selector code
   function logic ev(input logic [6:0] c, input logic f);
      ev = (c == 7'h00) ? 1'b0 : (c == 7'h01) ? f : c[0] ^ f;
   endfunction
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         fail_count++;
         stop_test;
      end
   end
   initial
   begin
      {resetn, psel, penable, pwrite, flip} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rows = '{16'hff81, 16'hff82, 16'h8305, 16'hfe00, 16'h0a41, 16'h0100, 16'h7f40};
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      for (n = 0; n < 2; n++)
      begin
         flip <= n[0];
         for (i = 0; i < 7; i++) xfer(1'b1, 12'(i * 4), {16'hffff, rows[i]});
         repeat (8) @(posedge mclk);
         for (i = 0; i < 7; i++)
         begin
            xfer(1'b0, 12'(i * 4), 32'h0);
            chk("readback", rd, {16'h0, rows[i] & (i == 1 ? 16'h007f : 16'h7f7f)});
            chk("error", 32'(er), 32'h0);
            chk("route lo", 32'(routed[2*i]), 32'(ev(rows[i][6:0], flip)));
            chk("route hi", 32'(routed[2*i+1]),
               32'(i == 1 ? 1'b0 : ev(rows[i][14:8], flip)));
         end
      end
      xfer(1'b1, 12'h01c, 32'hffffffff);
      chk("unmapped write", 32'(er), 32'h1);
      xfer(1'b0, 12'h01c, 32'h0);
      chk("unmapped read", rd, 32'h0);
      xfer(1'b1, 12'h018, 32'h0);
      repeat (2) @(posedge mclk);
      chk("fault cleared", 32'(flt), 32'h0);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      xfer(1'b1, 12'h018, 32'h0);
      xfer(1'b0, 12'h000, 32'h0);
      chk("reset value", rd, 32'h0);
      chk("reset routes", 32'(routed), 32'h0);
      stop_test;
   end
endmodule // testbench
